//--- sbm_regs.vh
// register offsets, field positions, reset values and timing counts for the byte request master
`ifndef SBM_REGS_VH
`define SBM_REGS_VH
`define OFS_BYTE_BUFFER 8'hb0
`define OFS_TARGET_BYTE_OFFSET 8'hb1
`define OFS_TARGET_DEVICE_SELECT 8'hb2
`define OFS_CONTROL_STATUS 8'hb3
`define RST_BYTE 8'h00
`define BIT_SHORT_PROTOCOL 7
`define BIT_IN_FLIGHT 5
`define BIT_LINK_TEST 2
`define BIT_REQUEST_ERROR 1
`define BIT_DIRECTION 0
`define CLK_HZ 50000000
`define SCL_NORMAL_HZ 100000
`define SCL_TEST_HZ 400000
`define QUARTER_NORMAL (`CLK_HZ / (4 * `SCL_NORMAL_HZ))
`define QUARTER_TEST (`CLK_HZ / (4 * `SCL_TEST_HZ))
`endif

//--- bit_phase_timer.v
// quarter-bit tick generator for the serial clock
`timescale 1ns/1ps
module bit_phase_timer #(
	parameter integer NORMAL_COUNT = 125,
	parameter integer TEST_COUNT = 31
)(
	input wire mclk,
	input wire nrst,
	input wire ce,
	input wire run,
	input wire fast,
	output reg tick
);
	reg [7:0] count_reg;
	wire [7:0] limit = fast ? TEST_COUNT[7:0] - 8'h01 : NORMAL_COUNT[7:0] - 8'h01;
	// restarts whenever the engine idles so the first phase is full length
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			count_reg <= 8'h00;
			tick <= 1'b0;
		end
		else if (ce)
		begin
			tick <= 1'b0;
			if (!run)
				count_reg <= 8'h00;
			else if (count_reg >= limit)
			begin
				count_reg <= 8'h00;
				tick <= 1'b1;
			end
			else
				count_reg <= count_reg + 8'h01;
		end
	end
endmodule // bit_phase_timer

//--- serial_bus_byte_request_master.v
// byte read/write request master for a two-wire serial bus
// Functional notes
// (R1) software loads data, index, then target for write
// (R2) software loads index, target, polls busy for read
// (R3) read byte lands in buffer before busy clears
// (R4) byte buffer: 8-bit rw, resets zero
// (R5) index register: 8-bit rw, resets zero
// (R6) target bits 7-1 give device address
// (R7) target bit 0: 0 write, 1 read
// (R8) registers at b0h, b1h, b2h, read/write
// (R9) target write starts request, sets busy
// (R10) short protocol skips index byte
// (R11) missing acknowledge sets error, write-one clears
// (R12) serial clock near 100 kHz normally
// (R13) write and read framing with repeated start
`timescale 1ns/1ps
`include "sbm_regs.vh"
module serial_bus_byte_request_master (
	input wire mclk,
	input wire nrst,
	input wire ce,
	input wire cfg_wr,
	input wire cfg_rd,
	input wire [7:0] cfg_addr,
	input wire [7:0] cfg_wdata,
	output reg [7:0] cfg_rdata,
	output reg cfg_rvalid,
	input wire scl_in,
	output reg scl_oe,
	input wire sda_in,
	output reg sda_oe
);
	localparam ST_IDLE = 4'd0;
	localparam ST_START = 4'd1;
	localparam ST_BIT = 4'd2;
	localparam ST_ACK = 4'd3;
	localparam ST_RSTART = 4'd4;
	localparam ST_STOP = 4'd5;
	localparam ST_RBIT = 4'd6;
	localparam ST_NACK = 4'd7;
	// byte being sent: 0 address(write), 1 index, 2 data, 3 address(read)
	localparam B_ADDR = 2'd0;
	localparam B_INDEX = 2'd1;
	localparam B_DATA = 2'd2;
	localparam B_RADDR = 2'd3;

	reg [7:0] byte_buffer_reg;
	reg [7:0] target_byte_offset_reg;
	reg [7:0] target_device_select_reg;
	reg short_protocol_select_reg;
	reg link_test_reg;
	reg request_error_reg;
	reg request_in_flight;
	reg [3:0] state_reg;
	reg [1:0] phase_reg;
	reg [2:0] bit_reg;
	reg [1:0] which_reg;
	reg [7:0] shift_reg;
	reg err_event;
	reg done_event;
	reg [7:0] rx_byte;
	reg sda_s1, sda_s2, scl_s1, scl_s2;
	wire tick;

	bit_phase_timer #(
		.NORMAL_COUNT(`QUARTER_NORMAL),
		.TEST_COUNT(`QUARTER_TEST)
	) timer_u (
		.mclk(mclk),
		.nrst(nrst),
		.ce(ce),
		.run(request_in_flight),
		.fast(link_test_reg),
		.tick(tick)
	); // R12

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers; scl is sampled only for completeness of the pair
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
		end
		else if (ce)
		begin
			sda_s1 <= sda_in;
			sda_s2 <= sda_s1;
			scl_s1 <= scl_in;
			scl_s2 <= scl_s1;
		end
	end

	wire write_hit = cfg_wr && !request_in_flight;
	wire start_req = write_hit && cfg_addr == `OFS_TARGET_DEVICE_SELECT;

	////////////////////////////////////////////////////////////////////////
	// configuration registers; writes during a request, except the write-one error
	// clear, are dropped so the request sees stable operands
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			byte_buffer_reg <= `RST_BYTE;
			target_byte_offset_reg <= `RST_BYTE;
			target_device_select_reg <= `RST_BYTE;
			short_protocol_select_reg <= 1'b0;
			link_test_reg <= 1'b0;
			request_error_reg <= 1'b0;
			cfg_rdata <= 8'h00;
			cfg_rvalid <= 1'b0;
		end
		else if (ce)
		begin
			if (write_hit && cfg_addr == `OFS_BYTE_BUFFER)
				byte_buffer_reg <= cfg_wdata; // R4 R8
			if (write_hit && cfg_addr == `OFS_TARGET_BYTE_OFFSET)
				target_byte_offset_reg <= cfg_wdata; // R5 R8
			if (start_req)
				target_device_select_reg <= cfg_wdata; // R6 R7 R8
			if (write_hit && cfg_addr == `OFS_CONTROL_STATUS)
			begin
				short_protocol_select_reg <= cfg_wdata[`BIT_SHORT_PROTOCOL];
				link_test_reg <= cfg_wdata[`BIT_LINK_TEST];
			end
			if (done_event)
				byte_buffer_reg <= rx_byte; // R3
			// set beats the write-one clear
			if (err_event)
				request_error_reg <= 1'b1; // R11
			else if (cfg_wr && cfg_addr == `OFS_CONTROL_STATUS && cfg_wdata[`BIT_REQUEST_ERROR])
				request_error_reg <= 1'b0; // R11
			cfg_rvalid <= cfg_rd;
			case (cfg_addr)
				`OFS_BYTE_BUFFER: cfg_rdata <= byte_buffer_reg;
				`OFS_TARGET_BYTE_OFFSET: cfg_rdata <= target_byte_offset_reg;
				`OFS_TARGET_DEVICE_SELECT: cfg_rdata <= target_device_select_reg;
				`OFS_CONTROL_STATUS: cfg_rdata <= {short_protocol_select_reg, 1'b0,
					request_in_flight, 2'b00, link_test_reg, request_error_reg, 1'b0}; // R9
				default: cfg_rdata <= 8'h00;
			endcase
		end
	end

	wire is_read = target_device_select_reg[`BIT_DIRECTION]; // R7
	wire [7:0] read_addr = {target_device_select_reg[7:1], 1'b1};
	wire [7:0] write_addr = {target_device_select_reg[7:1], 1'b0}; // R6

	////////////////////////////////////////////////////////////////////////
	// bit engine; each bit is four quarter phases: low, low, high, high
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_reg <= ST_IDLE;
			phase_reg <= 2'd0;
			bit_reg <= 3'd7;
			which_reg <= B_ADDR;
			shift_reg <= 8'h00;
			rx_byte <= 8'h00;
			request_in_flight <= 1'b0;
			err_event <= 1'b0;
			done_event <= 1'b0;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
		end
		else if (ce)
		begin
			err_event <= 1'b0;
			done_event <= 1'b0;
			if (start_req)
			begin
				request_in_flight <= 1'b1; // R9
				state_reg <= ST_START;
				phase_reg <= 2'd0;
				// short form sends the address with the wanted direction at once
				which_reg <= (short_protocol_select_reg && cfg_wdata[0]) ? B_RADDR : B_ADDR; // R10
				shift_reg <= short_protocol_select_reg ? cfg_wdata : {cfg_wdata[7:1], 1'b0};
			end
			else if (tick)
			begin
				phase_reg <= phase_reg + 2'd1;
				case (state_reg)
					ST_START, ST_RSTART:
					begin
						// a repeated start first pulls scl low so the target lets go of
						// its acknowledge; then sda falls while scl is high, then scl falls
						scl_oe <= (phase_reg == 2'd3) || (state_reg == ST_RSTART && phase_reg == 2'd0);
						sda_oe <= (phase_reg >= 2'd2);
						if (phase_reg == 2'd3)
						begin
							state_reg <= ST_BIT;
							bit_reg <= 3'd7;
						end
					end
					ST_BIT:
					begin
						scl_oe <= phase_reg[1] ? 1'b0 : 1'b1;
						// data moves a quarter after scl falls, never on the same edge,
						// so no target can mistake it for a start
						if (phase_reg == 2'd1)
							sda_oe <= !shift_reg[7];
						if (phase_reg == 2'd3)
						begin
							shift_reg <= {shift_reg[6:0], 1'b0};
							bit_reg <= bit_reg - 3'd1;
							if (bit_reg == 3'd0)
								state_reg <= ST_ACK;
						end
					end
					ST_ACK:
					begin
						scl_oe <= !phase_reg[1];
						if (phase_reg == 2'd1)
							sda_oe <= 1'b0;
						if (phase_reg == 2'd3)
						begin
							bit_reg <= 3'd7;
							if (sda_s2)
							begin
								err_event <= 1'b1; // R11
								state_reg <= ST_STOP;
							end
							else if (which_reg == B_RADDR)
								state_reg <= ST_RBIT;
							else if (which_reg == B_ADDR && !short_protocol_select_reg)
							begin
								which_reg <= B_INDEX; // R13
								shift_reg <= target_byte_offset_reg;
								state_reg <= ST_BIT;
							end
							else if (which_reg == B_INDEX && is_read)
							begin
								which_reg <= B_RADDR; // R13
								shift_reg <= read_addr;
								state_reg <= ST_RSTART;
							end
							else if (which_reg != B_DATA)
							begin
								which_reg <= B_DATA;
								shift_reg <= byte_buffer_reg;
								state_reg <= ST_BIT;
							end
							else
								state_reg <= ST_STOP;
						end
					end
					ST_RBIT:
					begin
						scl_oe <= !phase_reg[1];
						sda_oe <= 1'b0;
						if (phase_reg == 2'd2)
							rx_byte <= {rx_byte[6:0], sda_s2};
						if (phase_reg == 2'd3)
						begin
							bit_reg <= bit_reg - 3'd1;
							if (bit_reg == 3'd0)
								state_reg <= ST_NACK;
						end
					end
					ST_NACK:
					begin
						// master releases sda: not-acknowledge ends the read
						scl_oe <= !phase_reg[1];
						sda_oe <= 1'b0;
						if (phase_reg == 2'd3)
						begin
							state_reg <= ST_STOP; // R13
							// buffer takes the byte here, well before busy drops
							done_event <= 1'b1; // R3
						end
					end
					ST_STOP:
					begin
						// scl low, then sda low, then scl high, then sda high; a cut
						// request also ends here, so a failed read leaves the buffer alone
						scl_oe <= (phase_reg <= 2'd1);
						if (phase_reg == 2'd1)
							sda_oe <= 1'b1;
						if (phase_reg == 2'd3)
						begin
							state_reg <= ST_IDLE;
							request_in_flight <= 1'b0; // R9
							sda_oe <= 1'b0;
						end
					end
					default:
					begin
						state_reg <= ST_IDLE;
						scl_oe <= 1'b0;
						sda_oe <= 1'b0;
					end
				endcase
			end
		end
	end
	wire unused_scl = scl_s2;
endmodule // serial_bus_byte_request_master

//--- sbm_chk.sv
// port assertions for the byte request master
`timescale 1ns/1ps
module sbm_chk (
	input wire mclk,
	input wire nrst,
	input wire ce,
	input wire cfg_wr,
	input wire cfg_rd,
	input wire [7:0] cfg_addr,
	input wire [7:0] cfg_wdata,
	input wire [7:0] cfg_rdata,
	input wire cfg_rvalid,
	input wire scl_in,
	input wire scl_oe,
	input wire sda_in,
	input wire sda_oe
);
reg [11:0] lo_cnt;
////////////////////////////////////////
// length of each driven-low clock phase
always @(posedge mclk or negedge nrst)
	if (!nrst)
		lo_cnt <= 12'h000;
	else
		lo_cnt <= scl_oe ? lo_cnt + 12'h001 : 12'h000;
////////////////////////////////////////
default clocking cb @(posedge mclk); endclocking
default disable iff (!nrst);
// buffer write then read two cycles on
sequence s_buf_wr;
	ce && cfg_wr && cfg_addr == 8'hb0;
endsequence
sequence s_buf_rd;
	ce && cfg_rd && cfg_addr == 8'hb0;
endsequence
a_rvalid_follows: assert property (ce && cfg_rd |=> cfg_rvalid) else $error("no rvalid");
a_rvalid_cause: assert property (cfg_rvalid |-> $past(ce && cfg_rd)) else $error("stray rvalid");
a_unmapped_zero: assert property (ce && cfg_rd && (cfg_addr < 8'hb0 || cfg_addr > 8'hb3)
	|=> cfg_rdata == 8'h00) else $error("unmapped read not zero");
a_buf_readback: assert property (s_buf_wr ##2 s_buf_rd |=> cfg_rdata == $past(cfg_wdata, 3))
	else $error("buffer readback wrong");
a_ce_freeze: assert property (!ce |=> $stable(scl_oe) && $stable(sda_oe))
	else $error("outputs moved with ce low");
a_scl_low_min: assert property ($fell(scl_oe) |-> lo_cnt >= 12'd30)
	else $error("clock low phase too short");
a_stop_idle: assert property ($fell(sda_oe) && !scl_oe && $past(!scl_oe)
	|-> (!scl_oe && !sda_oe) [*8]) else $error("bus not idle after stop");
a_start_hold: assert property ($rose(sda_oe) && !scl_oe |=> sda_oe [*8])
	else $error("start not held");
endmodule // sbm_chk
bind serial_bus_byte_request_master sbm_chk chk_u (.mclk(mclk), .nrst(nrst), .ce(ce),
	.cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
	.cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .scl_in(scl_in), .scl_oe(scl_oe),
	.sda_in(sda_in), .sda_oe(sda_oe));

//--- sbm_target.sv
// behavioural two-wire target holding a byte memory
`timescale 1ns/1ps
module sbm_target #(
	parameter [6:0] ADDR = 7'h50
)(
	input wire scl,
	input wire sda,
	output reg sda_oe
);
reg [7:0] mem [0:255];
reg [7:0] sh;
reg [7:0] idx;
reg [3:0] n;
reg [1:0] ph;
reg rd;
reg hit;
integer k;
initial
begin
	sda_oe = 1'b0;
	n = 4'h0;
	ph = 2'h0;
	idx = 8'h00;
	for (k = 0; k < 256; k = k + 1)
		mem[k] = 8'h00;
end
////////////////////////////////////////
// start or repeated start restarts framing
always @(negedge sda)
	if (scl)
	begin
		n = 4'h0;
		ph = 2'h0;
	end
// bits are taken while the clock is high
always @(posedge scl)
begin
	sh = {sh[6:0], sda};
	n = n + 4'h1;
end
// answers change only while the clock is low
always @(negedge scl)
	if (n == 4'h8)
	begin
		if (ph == 2'h0)
		begin
			hit = (sh[7:1] == ADDR);
			rd = sh[0];
		end
		else if (ph == 2'h1 && !rd)
			idx = sh;
		else if (!rd && hit)
			mem[idx] = sh;
		sda_oe = hit && !(rd && ph != 2'h0);
	end
	else if (n == 4'h9)
	begin
		sda_oe = hit && rd && ph == 2'h0 && !mem[idx][7];
		n = 4'h0;
		ph = ph + 2'h1;
	end
	else if (rd && ph == 2'h1)
		sda_oe = hit && !mem[idx][4'h7 - n];
endmodule // sbm_target

//--- serial_bus_byte_request_master_tb_top.sv
// testbench for the byte request master
`timescale 1ns/1ps
module serial_bus_byte_request_master_tb_top;
reg mclk = 1'b0;
reg nrst = 1'b0;
reg ce = 1'b1;
reg cfg_wr = 1'b0;
reg cfg_rd = 1'b0;
reg [7:0] cfg_addr = 8'h00;
reg [7:0] cfg_wdata = 8'h00;
reg [7:0] rv;
reg [7:0] a;
wire [7:0] cfg_rdata;
wire cfg_rvalid;
wire scl_oe;
wire sda_oe;
wire tgt_oe;
wire scl_w = ~scl_oe;
wire sda_w = ~(sda_oe | tgt_oe);
integer error_cnt = 0;
integer n_tests = 0;
integer i;
always #10 mclk = ~mclk;
serial_bus_byte_request_master dut_u (.mclk(mclk), .nrst(nrst), .ce(ce), .cfg_wr(cfg_wr),
	.cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
	.cfg_rvalid(cfg_rvalid), .scl_in(scl_w), .scl_oe(scl_oe), .sda_in(sda_w), .sda_oe(sda_oe));
sbm_target tgt_u (.scl(scl_w), .sda(sda_w), .sda_oe(tgt_oe));
////////////////////////////////////////
task chk(input [7:0] seen, input [7:0] want);
begin
	n_tests = n_tests + 1;
	if (seen !== want)
	begin
		error_cnt = error_cnt + 1;
		$display("ERROR %0t: saw %h, expected %h", $time, seen, want);
	end
end
endtask
task test_done;
begin
	if (error_cnt == 0 && n_tests > 0)
		$display("ALL CHECKS OK");
	else
		$display("CHECKS NOT OK");
	$finish;
end
endtask
// register access, one cycle per request
task wr(input [7:0] ad, input [7:0] d);
begin
	@(posedge mclk) {cfg_wr, cfg_addr, cfg_wdata} <= {1'b1, ad, d};
	@(posedge mclk) cfg_wr <= 1'b0;
end
endtask
task rd(input [7:0] ad);
begin
	@(posedge mclk) {cfg_rd, cfg_addr} <= {1'b1, ad};
	@(posedge mclk) cfg_rd <= 1'b0;
	#1 rv = cfg_rdata;
	chk({7'h00, cfg_rvalid}, 8'h01);
end
endtask
// poll busy; a hang ends the run
task poll;
begin
	rv = 8'hff;
	for (i = 0; i < 20000 && rv[5] !== 1'b0; i = i + 1)
		rd(8'hb3);
	if (rv[5] !== 1'b0)
	begin
		error_cnt = error_cnt + 1;
		$display("ERROR %0t: busy stuck", $time);
		test_done;
	end
end
endtask
task go(input [7:0] ctl, input [7:0] dat, input [7:0] idx, input [7:0] tgt);
begin
	wr(8'hb3, ctl);
	wr(8'hb0, dat);
	wr(8'hb1, idx);
	wr(8'hb2, tgt);
end
endtask
////////////////////////////////////////
task t_regs;
begin
	for (a = 8'hb0; a != 8'hb4; a = a + 8'h01)
	begin
		rd(a);
		chk(rv, 8'h00);
	end
	rd(8'h40);
	chk(rv, 8'h00);
	wr(8'hb0, 8'h3c);
	rd(8'hb0);
	chk(rv, 8'h3c);
	wr(8'hb1, 8'hc3);
	rd(8'hb1);
	chk(rv, 8'hc3);
end
endtask
// normal speed write, refused write and a frozen spell
task t_write;
begin
	go(8'h00, 8'ha5, 8'h12, 8'ha0);
	rd(8'hb3);
	chk(rv, 8'h20);
	wr(8'hb1, 8'h77);
	@(posedge mclk) ce <= 1'b0;
	repeat (5) @(posedge mclk);
	ce <= 1'b1;
	poll;
	chk(rv, 8'h00);
	rd(8'hb1);
	chk(rv, 8'h12);
	rd(8'hb2);
	chk(rv, 8'ha0);
	chk(tgt_u.mem[8'h12], 8'ha5);
end
endtask
task t_read;
begin
	go(8'h04, 8'h00, 8'h12, 8'ha1);
	poll;
	rd(8'hb0);
	chk(rv, 8'ha5);
end
endtask
// short form must not send the new offset
task t_short;
begin
	go(8'h84, 8'h12, 8'h33, 8'ha0);
	poll;
	chk(tgt_u.idx, 8'h12);
	go(8'h84, 8'h00, 8'h33, 8'ha1);
	poll;
	rd(8'hb0);
	chk(rv, 8'ha5);
end
endtask
task t_nack;
begin
	go(8'h04, 8'h5a, 8'h12, 8'h23);
	poll;
	chk(rv, 8'h06);
	rd(8'hb0);
	chk(rv, 8'h5a);
	wr(8'hb3, 8'h06);
	rd(8'hb3);
	chk(rv, 8'h04);
end
endtask
initial
begin
	repeat (10) @(posedge mclk);
	nrst <= 1'b1;
	t_regs;
	t_write;
	t_read;
	t_short;
	t_nack;
	test_done;
end
endmodule // serial_bus_byte_request_master_tb_top
